// ==== design/kscl_defs.vh ====
// Constants for the keyboard scan-code link
`ifndef KSCL_DEFS_VH
`define KSCL_DEFS_VH
`define KSCL_NUM_KEYS 83
`define KSCL_BREAK_OFFSET 8'h80
`define KSCL_QUEUE_DEPTH 16
`define KSCL_QUEUE_AW 4
`define KSCL_CLK_HZ 20000000
`define KSCL_BIT_TIME_NS 400
`define KSCL_HALF_BIT_CYC ((`KSCL_BIT_TIME_NS * (`KSCL_CLK_HZ / 1000000)) / 2000)
`define KSCL_ACK_TIMEOUT_CYC 1024
`define KSCL_ROM_WORDS 16
`endif

// ==== design/kscl_keyboard.v ====
// Keyboard scanner, code queue and two-wire link sender
// How it works
// (RQ1) Key position n (1 to 83) is reported as the position code n, not as a character.
// (RQ2) Every key sends a make code on press and a separate break code on release.
// (RQ3) The break code is the make code plus hex 80.
// (RQ4) Up to 16 pending codes wait in an internal queue.
// (RQ5) On host request a self-test checks the code ROM, working memory and stuck keys.
// (RQ6) A code counts as delivered only after the host acknowledge handshake completes.
// (RQ7) The link is one clock line and one data line, each drivable from either end.
// (RQ8) The connector reset line is ignored and steers no state.
// (RQ9) Codes go out oldest first and stay queued until the host allows and acknowledges.
`include "kscl_defs.vh"
module kscl_keyboard #(
   parameter NUM_KEYS = `KSCL_NUM_KEYS,
   parameter HALF_BIT = `KSCL_HALF_BIT_CYC
) (
   input wire clock_i,
   input wire reset_i,
   input wire enable_i,
   input wire [NUM_KEYS-1:0] keys_i,
   input wire link_clk_i,
   output reg link_clk_o,
   output reg link_clk_oe_o,
   input wire link_data_i,
   output reg link_data_o,
   output reg link_data_oe_o,
   input wire kbd_reset_n_i,
   output reg test_done_o,
   output reg test_pass_o
);
   // One-hot states
   localparam ST_IDLE = 5'h01;
   localparam ST_SEND = 5'h02;
   localparam ST_ACK = 5'h04;
   localparam ST_TEST = 5'h08;
   localparam ST_RESULT = 5'h10;
   // Result bytes, sent in place of a scan code, and the expected ROM sum
   localparam [7:0] TEST_OK = 8'hAA;
   localparam [7:0] TEST_FAIL = 8'hFC;
   localparam [7:0] ROM_SUM = 8'h78;

   // Two-stage synchronisers for the key matrix and both link wires
   reg [NUM_KEYS-1:0] key_s1_reg;
   reg [NUM_KEYS-1:0] key_s2_reg;
   // Last level reported per key; only updated once its code is queued
   reg [NUM_KEYS-1:0] key_prev_reg;
   reg clk_s1_reg;
   reg clk_s2_reg;
   reg dat_s1_reg;
   reg dat_s2_reg;
   reg clk_prev_reg;
   // Code queue; pointers carry one extra wrap bit to tell full from empty
   reg [7:0] queue_mem [0:`KSCL_QUEUE_DEPTH-1];
   reg [`KSCL_QUEUE_AW:0] wr_ptr_reg;
   reg [`KSCL_QUEUE_AW:0] rd_ptr_reg;
   reg [4:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [9:0] phase_cnt_reg;
   reg [10:0] ack_cnt_reg;
   reg [8:0] shift_reg;
   reg [7:0] scan_idx_reg;
   reg [7:0] test_cnt_reg;
   reg [7:0] sum_reg;
   reg mem_ok_reg;
   reg [7:0] result_reg;
   reg [7:0] ram_mem [0:`KSCL_QUEUE_DEPTH-1];

   wire [`KSCL_QUEUE_AW-1:0] wr_addr = wr_ptr_reg[`KSCL_QUEUE_AW-1:0];
   wire [`KSCL_QUEUE_AW-1:0] rd_addr = rd_ptr_reg[`KSCL_QUEUE_AW-1:0];
   wire q_empty = (wr_ptr_reg == rd_ptr_reg);
   wire q_full = (wr_addr == rd_addr) &&
      (wr_ptr_reg[`KSCL_QUEUE_AW] != rd_ptr_reg[`KSCL_QUEUE_AW]);
   wire host_allows = clk_s2_reg && dat_s2_reg;
   wire clk_rise = clk_s2_reg && !clk_prev_reg;
   // Our own release of the clock wire shows up as a rise at count 3;
   // only a later rise is the host's acknowledge pulse
   wire host_ack = clk_rise && (ack_cnt_reg > 11'h003);
   // A pending result blocks a new test, so a clock held low runs it once
   wire test_req = !clk_s2_reg && !link_clk_oe_o && (state_reg == ST_IDLE) &&
      (result_reg == 8'h00);
   wire scan_now = key_s2_reg[scan_idx_reg[6:0]];
   wire scan_old = key_prev_reg[scan_idx_reg[6:0]];
   wire scan_chg = scan_now != scan_old;
   wire [7:0] make_code = scan_idx_reg + 8'h01;                        // RQ1
   wire [7:0] scan_code = scan_now ? make_code : make_code + `KSCL_BREAK_OFFSET; // RQ2 RQ3
   wire [7:0] rom_word = {4'h0, test_cnt_reg[3:0]};
   // Pass needs ROM sum, memory pattern and no key held down
   wire test_ok = mem_ok_reg && (sum_reg == ROM_SUM) && (key_s2_reg == {NUM_KEYS{1'b0}});

   // One clocked process; enable_i low freezes every register
   always @(posedge clock_i) begin
      if (reset_i) begin
         key_s1_reg <= {NUM_KEYS{1'b0}};
         key_s2_reg <= {NUM_KEYS{1'b0}};
         key_prev_reg <= {NUM_KEYS{1'b0}};
         clk_s1_reg <= 1'b1;
         clk_s2_reg <= 1'b1;
         dat_s1_reg <= 1'b1;
         dat_s2_reg <= 1'b1;
         clk_prev_reg <= 1'b1;
         wr_ptr_reg <= 5'h00;
         rd_ptr_reg <= 5'h00;
         state_reg <= ST_IDLE;
         bit_cnt_reg <= 4'h0;
         phase_cnt_reg <= 10'h000;
         ack_cnt_reg <= 11'h000;
         shift_reg <= 9'h000;
         scan_idx_reg <= 8'h00;
         test_cnt_reg <= 8'h00;
         sum_reg <= 8'h00;
         mem_ok_reg <= 1'b1;
         result_reg <= 8'h00;
         link_clk_o <= 1'b0;
         link_clk_oe_o <= 1'b0;
         link_data_o <= 1'b0;
         link_data_oe_o <= 1'b0;
         test_done_o <= 1'b0;
         test_pass_o <= 1'b0;
      end else if (enable_i) begin
         // Pins are asynchronous to clock_i; kbd_reset_n_i is never sampled
         key_s1_reg <= keys_i;                                         // RQ8
         key_s2_reg <= key_s1_reg;
         clk_s1_reg <= link_clk_i;
         clk_s2_reg <= clk_s1_reg;
         dat_s1_reg <= link_data_i;
         dat_s2_reg <= dat_s1_reg;
         clk_prev_reg <= clk_s2_reg;
         // Round-robin scan; a change is only latched once queued, so a full
         // queue delays the report instead of losing it
         // Scanning pauses during the self-test
         if (state_reg != ST_TEST) begin
            if (!scan_chg || !q_full) begin
               scan_idx_reg <= (scan_idx_reg == NUM_KEYS - 1) ? 8'h00 : scan_idx_reg + 8'h01;
            end
            if (scan_chg && !q_full) begin                             // RQ4
               queue_mem[wr_addr] <= scan_code;
               wr_ptr_reg <= wr_ptr_reg + 5'h01;
               key_prev_reg[scan_idx_reg[6:0]] <= scan_now;
            end
         end
         case (state_reg)
            ST_IDLE: begin
               link_clk_oe_o <= 1'b0;
               link_data_oe_o <= 1'b0;
               if (test_req) begin                                     // RQ5
                  state_reg <= ST_TEST;
                  test_cnt_reg <= 8'h00;
                  sum_reg <= 8'h00;
                  mem_ok_reg <= 1'b1;
                  test_done_o <= 1'b0;
               end else if ((!q_empty || result_reg != 8'h00) && host_allows) begin // RQ9
                  // Start bit 0, then 8 data bits LSB first
                  // Self-test result goes out ahead of any queued key codes
                  shift_reg <= {(result_reg != 8'h00) ? result_reg :
                     queue_mem[rd_addr], 1'b0};
                  bit_cnt_reg <= 4'h0;
                  // Starts one below zero: the enables rise a cycle later, and the
                  // first low half must still last HALF_BIT cycles
                  phase_cnt_reg <= 10'h3FF;
                  state_reg <= ST_SEND;
               end
            end
            ST_SEND: begin
               // Keyboard makes the link clock by division of clock_i
               // Data only moves while the clock is low; the host samples on the rise
               link_data_oe_o <= 1'b1;                                 // RQ7
               link_clk_oe_o <= 1'b1;
               link_data_o <= shift_reg[0];
               if (phase_cnt_reg == HALF_BIT - 1) begin
                  phase_cnt_reg <= 10'h000;
                  link_clk_o <= ~link_clk_o;
                  if (link_clk_o) begin
                     shift_reg <= {1'b1, shift_reg[8:1]};
                     if (bit_cnt_reg == 4'h8) begin
                        state_reg <= ST_ACK;
                        ack_cnt_reg <= 11'h000;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end else begin
                  phase_cnt_reg <= phase_cnt_reg + 10'h001;
               end
            end
            ST_ACK: begin
               // Release both lines; host pulses the clock low then high
               link_clk_oe_o <= 1'b0;
               link_data_oe_o <= 1'b0;
               link_clk_o <= 1'b0;
               ack_cnt_reg <= ack_cnt_reg + 11'h001;
               if (host_ack) begin                                     // RQ6
                  if (result_reg != 8'h00) begin
                     result_reg <= 8'h00;
                  end else begin
                     rd_ptr_reg <= rd_ptr_reg + 5'h01;                 // RQ9
                  end
                  state_reg <= ST_IDLE;
               end else if (ack_cnt_reg == `KSCL_ACK_TIMEOUT_CYC) begin
                  // No pulse from the host: pointer stays, so the code goes again
                  state_reg <= ST_IDLE;                                // Retry same code
               end
            end
            ST_TEST: begin
               // One pass: ROM sum, RAM write/read, stuck-key check
               test_cnt_reg <= test_cnt_reg + 8'h01;
               if (test_cnt_reg < `KSCL_ROM_WORDS) begin
                  sum_reg <= sum_reg + rom_word;                       // RQ5
                  ram_mem[test_cnt_reg[3:0]] <= ~test_cnt_reg;
               end else if (test_cnt_reg < 2 * `KSCL_ROM_WORDS) begin
                  if (ram_mem[test_cnt_reg[3:0]] != ~{4'h0, test_cnt_reg[3:0]})
                     mem_ok_reg <= 1'b0;
               end else begin
                  state_reg <= ST_RESULT;
               end
            end
            ST_RESULT: begin
               test_done_o <= 1'b1;
               test_pass_o <= test_ok;                                 // RQ5
               result_reg <= test_ok ? TEST_OK : TEST_FAIL;
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // kscl_keyboard

// ==== tb/kscl_keyboard_properties.sv ====
// Checker on the keyboard link outputs
module kscl_keyboard_properties (
   input wire clock_i,
   input wire reset_i,
   input wire link_clk_o,
   input wire link_clk_oe_o,
   input wire link_data_o,
   input wire link_data_oe_o,
   input wire test_done_o,
   input wire test_pass_o
);
   timeunit 1ns; timeprecision 1ns;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   chk_oe_together: assert property (link_clk_oe_o == link_data_oe_o)
      else $error("link enables differ");
   chk_start_low: assert property ($rose(link_clk_oe_o) |-> !link_clk_o && !link_data_o)
      else $error("frame start not low");
   chk_low_half: assert property ($rose(link_clk_oe_o) |-> !link_clk_o [*4] ##1 link_clk_o)
      else $error("first clock half wrong");
   chk_frame_len: assert property ($rose(link_clk_oe_o) |-> ##72 link_clk_oe_o ##1 !link_clk_oe_o)
      else $error("frame length wrong");
   chk_data_steady: assert property (link_clk_o && $past(link_clk_o) |-> $stable(link_data_o))
      else $error("data moved in high half");
   chk_ack_gap: assert property ($fell(link_clk_oe_o) |-> !link_clk_oe_o [*3])
      else $error("no wait for handshake");
   chk_pass_done: assert property ($rose(test_pass_o) |-> test_done_o)
      else $error("pass without done");
   chk_reset_quiet: assert property (disable iff (1'b0) reset_i |=> !link_clk_oe_o && !test_done_o)
      else $error("drive during reset");
   cover property ($rose(link_clk_oe_o));
   cover property ($rose(test_done_o));
   cover property ($rose(test_pass_o));
endmodule // kscl_keyboard_properties
bind kscl_keyboard kscl_keyboard_properties u_props (.clock_i, .reset_i, .link_clk_o,
   .link_clk_oe_o, .link_data_o, .link_data_oe_o, .test_done_o, .test_pass_o);

// ==== tb/kscl_host_model.sv ====
// Host side of the link: wire pull-ups, frame capture, acknowledge
module kscl_host_model (
   input wire clock_i,
   input wire hold_clk_i,
   input wire hold_dat_i,
   input wire noack_i,
   input wire kc_i,
   input wire kc_oe_i,
   input wire kd_i,
   input wire kd_oe_i,
   output wire clk_w_o,
   output wire dat_w_o,
   output reg [7:0] rx_o,
   output reg got_o
);
   timeunit 1ns; timeprecision 1ns;
   reg prev = 1'b1;
   reg [3:0] n = 4'h0;
   reg [3:0] ack = 4'h0;
   assign clk_w_o = kc_oe_i ? kc_i : !(hold_clk_i || ack != 4'h0);
   assign dat_w_o = kd_oe_i ? kd_i : !hold_dat_i;
   always @(posedge clock_i) begin
      prev <= clk_w_o;
      got_o <= 1'b0;
      if (ack != 4'h0) ack <= ack - 4'h1;
      if (!prev && clk_w_o && kc_oe_i) begin
         n <= n + 4'h1;
         if (n != 4'h0) rx_o <= {dat_w_o, rx_o[7:1]};
      end
      if (n == 4'h9 && !kc_oe_i) begin
         n <= 4'h0;
         got_o <= 1'b1;
         // Long enough to pass the keyboard's 2-FF sync
         if (!noack_i) ack <= 4'h8;
      end
   end
endmodule // kscl_host_model

// ==== tb/kscl_keyboard_tb_top.sv ====
// Testbench for the keyboard scan-code link
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
module kscl_keyboard_tb_top;
   timeunit 1ns; timeprecision 1ns;
   reg clock_i = 0, reset_i = 1, krst_n = 1, hc = 0, hd = 0, na = 0, en = 1;
   reg [82:0] keys = 83'h0;
   wire cw, dw, got, lc, lce, ld, lde, done, pass;
   wire [7:0] rx;
   int n_fail = 0, num_checks = 0, k;
   always #25 clock_i = ~clock_i;
   kscl_keyboard uut (.clock_i(clock_i), .reset_i(reset_i), .enable_i(en), .keys_i(keys),
      .link_clk_i(cw), .link_clk_o(lc), .link_clk_oe_o(lce), .link_data_i(dw), .link_data_o(ld),
      .link_data_oe_o(lde), .kbd_reset_n_i(krst_n), .test_done_o(done), .test_pass_o(pass));
   kscl_host_model host (.clock_i(clock_i), .hold_clk_i(hc), .hold_dat_i(hd), .noack_i(na),
      .kc_i(lc), .kc_oe_i(lce), .kd_i(ld), .kd_oe_i(lde), .clk_w_o(cw), .dat_w_o(dw),
      .rx_o(rx), .got_o(got));
   task finish_test;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task tick;
      @(posedge clock_i);
      #1;
   endtask
   task key(input int p, input bit v);
      @(posedge clock_i);
      keys[p-1] <= v;
   endtask
   task get_byte(input [7:0] e);
      int i;
      for (i = 0; i < 3000 && got !== 1'b1; i++) tick();
      if (i == 3000) begin
         n_fail++;
         $display("ERROR %0t no byte from keyboard", $time);
         finish_test();
      end else begin
         `CHK(rx, e)
         tick();
      end
   endtask
   task t_codes;
      @(posedge clock_i) krst_n <= 1'b0;
      key(1, 1); get_byte(8'h01);
      key(1, 0); get_byte(8'h81);
      key(83, 1); get_byte(8'h53);
      key(83, 0); get_byte(8'hD3);
      @(posedge clock_i) krst_n <= 1'b1;
      $display("t_codes done");
   endtask
   task t_queue;
      // Data held low blocks sending, so codes pile past the queue depth
      @(posedge clock_i) hd <= 1'b1;
      for (k = 1; k <= 18; k++) begin key(k, 1); repeat (100) tick(); end
      @(posedge clock_i) hd <= 1'b0;
      for (k = 1; k <= 18; k++) get_byte(k[7:0]);
      for (k = 1; k <= 18; k++) begin key(k, 0); get_byte(8'h80 + k[7:0]); end
      $display("t_queue done");
   endtask
   task t_resend;
      @(posedge clock_i) na <= 1'b1;
      key(4, 1); get_byte(8'h04);
      @(posedge clock_i) na <= 1'b0;
      get_byte(8'h04);
      key(4, 0); get_byte(8'h84);
      $display("t_resend done");
   endtask
   task t_freeze;
      int i;
      int seen;
      seen = 0;
      repeat (30) tick();
      @(posedge clock_i) en <= 1'b0;
      key(2, 1);
      for (i = 0; i < 300; i++) begin
         tick();
         if (got === 1'b1 || lce === 1'b1) seen++;
      end
      `CHK(seen, 0)
      @(posedge clock_i) en <= 1'b1;
      get_byte(8'h02);
      key(2, 0); get_byte(8'h82);
      $display("t_freeze done");
   endtask
   task self_test(input bit want, input [7:0] code);
      int i;
      int j;
      // Let the previous handshake finish before holding the clock low
      repeat (30) tick();
      @(posedge clock_i) hc <= 1'b1;
      for (i = 0; i < 300 && done !== 1'b0; i++) tick();
      for (j = 0; j < 300 && done !== 1'b1; j++) tick();
      if (i == 300 || j == 300) begin
         n_fail++;
         $display("ERROR %0t self-test timeout", $time);
         finish_test();
      end else begin
         `CHK(pass, want)
         @(posedge clock_i) hc <= 1'b0;
         get_byte(code);
      end
   endtask
   task t_selftest;
      key(5, 1); get_byte(8'h05);
      self_test(1'b0, 8'hFC);
      key(5, 0); get_byte(8'h85);
      self_test(1'b1, 8'hAA);
      $display("t_selftest done");
   endtask
   initial begin
      repeat (10) @(posedge clock_i);
      reset_i <= 1'b0;
      t_codes();
      t_queue();
      t_resend();
      t_freeze();
      t_selftest();
      finish_test();
   end
endmodule // kscl_keyboard_tb_top
